// [rtl/ep_ctrl_defs.svh]
/*
 * offsets, field positions, layout masks and reset values of the
 * endpoint control set/clear block.
 * assumes: included by bare name after the package is compiled.
 */
`ifndef EP_CTRL_DEFS_SVH
`define EP_CTRL_DEFS_SVH

// ***************************************************************
// address map
// ***************************************************************
`define EPC_NUM_EP 7
`define EPC_REGION 24'hF803C1
`define EPC_EP0_SET 32'hF803C104
`define EPC_EP0_CLR 32'hF803C108
`define EPC_EP0_STATE 32'hF803C10C
`define EPC_EP_STRIDE 32'h00000020
`define EPC_OFS_SET 5'h04
`define EPC_OFS_CLR 5'h08
`define EPC_OFS_STATE 5'h0C
`define EPC_IRQ_STATUS 32'hF803C1E0
`define EPC_IRQ_MASK 32'hF803C1E4

// ***************************************************************
// control state fields
// ***************************************************************
`define EPC_B_ON 0
`define EPC_B_AUTO 1
`define EPC_B_IRQ_DMA 3
`define EPC_B_NYET 4
`define EPC_B_DATAX 6
`define EPC_B_MDATA 7
`define EPC_B_OVFLW 8
`define EPC_B_RXRDY 9
`define EPC_B_TXCMP 10
`define EPC_B_TX_READY 11
`define EPC_B_SETUP 12
`define EPC_B_STALL 13
`define EPC_B_NAKIN 14
`define EPC_B_NAKOUT 15
`define EPC_B_ISO_FLOW 12
`define EPC_B_ISO_CRC 13
`define EPC_B_ISO_FLUSH 14
`define EPC_B_BUSY 18
`define EPC_B_SHORT 31

// writable bits of each layout; all others are reserved
`define EPC_MASK_STD 32'h8004FF1B
`define EPC_MASK_ISO 32'h80047FCB
// interrupt enable positions of both layouts
`define EPC_MASK_IRQ_EN 32'h8004FFC0

`define EPC_STATE_RST 32'h00000000
`define EPC_IRQ_RST 7'h00
`define EPC_RESP_OKAY 2'h0
`define EPC_RESP_SLVERR 2'h2

`endif

// [rtl/ep_ctrl_pkg.sv]
/*
 * types of the endpoint control set/clear block.
 * assumes: nothing; compiled first.
 */
`default_nettype none

package ep_ctrl_pkg;

   // endpoint kind field of the configuration register
   typedef enum logic [1:0]
   {
      KIND_CTRL = 2'b00,
      KIND_ISO = 2'b01,
      KIND_BULK = 2'b10,
      KIND_INTR = 2'b11
   } ep_kind_e;

   typedef enum logic [0:0]
   {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } rd_state_e;

   // per-endpoint controls handed to the protocol engine and dma
   typedef struct packed
   {
      logic on;
      logic auto_commit;
      logic force_ack;
      logic short_guarantee;
      logic dma_req;
   } ep_ctrl_s;

endpackage

`default_nettype wire

// [rtl/ep_ctrl_set_clear.sv]
/*
 * endpoint control state with write-only set and clear views, a
 * read-only state view, an interrupt status/mask pair and an
 * axi4-lite slave, for seven endpoints.
 * assumes: endpoint kind, direction, interrupt sources, bank state
 * and dma request come from logic on core_clk_i; single-beat
 * axi4-lite master with one write and one read outstanding.
 */
`include "ep_ctrl_defs.svh"
`default_nettype none

// Operation
// - set view: ones set matching control bits, zeros leave state alone
// - clear view: ones clear matching control bits, zeros leave state
// - iso layout when kind is 0x1, standard layout for 0x0, 0x2, 0x3
// - bit 0 enables endpoint via set view, disables via clear view
// - auto-commit bit 1 validates packet and switches bank, in and out
// - irq-blocks-dma bit 3 withdraws dma request on enabled endpoint irq
// - standard bit 4 forces ack instead of nyet; clearing returns to hw
// - bit 31: out short-packet irq; in short packet with buffer-end, auto
// - clearing bit 31 on in endpoints stops automatic zero-length packet
// - standard layout: setup 12, stall 13, nak in 14, nak out 15
// - both layouts: overflow 8, out data 9, in complete 10, tx ready 11
// - both layouts: busy bank irq enable at bit 18
// - iso layout: flow error 12, crc/count error 13, flush error 14
// - iso layout: bit 6 data pid, bit 7 more-data pid irq enables
// - set view at 0xF803C104 plus 0x20 per endpoint, both layouts
// - clear view at 0xF803C108 plus 0x20 per endpoint, both layouts
// - control state readable through read-only state view
// - busy bank fires: out when all banks busy, in when all free
module ep_ctrl_set_clear
   import ep_ctrl_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [6:0][1:0] ep_kind_i,
   input wire logic [6:0] ep_dir_in_i,
   input wire logic [6:0][31:0] ep_irq_src_i,
   input wire logic [6:0] all_banks_busy_i,
   input wire logic [6:0] all_banks_free_i,
   input wire logic [6:0] end_buf_en_i,
   input wire logic [6:0] dma_req_i,
   output logic [6:0][31:0] ep_state_o,
   output ep_ctrl_s [6:0] ep_ctrl_o,
   output logic [6:0] ep_irq_o,
   output logic irq_o
);

   // ************************************************************
   // write channel
   // ************************************************************
   logic aw_have_q;
   logic aw_have_d;
   logic w_have_q;
   logic w_have_d;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic awready_q;
   logic wready_q;
   logic aw_take;
   logic w_take;
   logic wr_fire;

   // each half is taken on its own; the write lands once both are held
   // and no response waits, so a slow bready stalls the next write
   assign aw_take = s_axi_awvalid_i && awready_q;
   assign w_take = s_axi_wvalid_i && wready_q;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign aw_have_d = (aw_have_q && !wr_fire) || aw_take;
   assign w_have_d = (w_have_q && !wr_fire) || w_take;
   assign bvalid_d = wr_fire || (bvalid_q && !s_axi_bready_i);

   // decode of the captured write address
   logic wr_in_region;
   logic [2:0] wr_ep;
   logic [4:0] wr_ofs;
   logic wr_is_set;
   logic wr_is_clr;
   logic wr_is_status;
   logic wr_is_mask;
   logic wr_ok;
   logic [31:0] wr_bits;

   assign wr_in_region = aw_addr_q[31:8] == `EPC_REGION;
   assign wr_ep = aw_addr_q[7:5];
   assign wr_ofs = aw_addr_q[4:0];
   assign wr_is_set = wr_in_region && wr_ep != 3'h7
      && wr_ofs == `EPC_OFS_SET;
   assign wr_is_clr = wr_in_region && wr_ep != 3'h7
      && wr_ofs == `EPC_OFS_CLR;
   assign wr_is_status = aw_addr_q == `EPC_IRQ_STATUS;
   assign wr_is_mask = aw_addr_q == `EPC_IRQ_MASK;
   assign wr_ok = wr_is_set || wr_is_clr || wr_is_status || wr_is_mask;

   // byte lanes not strobed carry no ones
   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_lane
         assign wr_bits[8*b +: 8] = w_strb_q[b] ? w_data_q[8*b +: 8]
            : 8'h00;
      end
   endgenerate

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `EPC_RESP_OKAY;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         bvalid_q <= bvalid_d;
         // ready is registered, so it drops the edge a half is taken
         awready_q <= !aw_have_d && !bvalid_d;
         wready_q <= !w_have_d && !bvalid_d;
         if (wr_fire)
         begin
            bresp_q <= wr_ok ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
         end
      end
   end

   // holding registers need no reset: they are read only under wr_fire
   always_ff @(posedge core_clk_i)
   begin
      if (aw_take)
      begin
         aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_take)
      begin
         w_data_q <= s_axi_wdata_i;
         w_strb_q <= s_axi_wstrb_i;
      end
   end

   // ************************************************************
   // per-endpoint control state
   // ************************************************************
   logic [6:0][31:0] state_q;
   logic [6:0][31:0] state_d;
   logic [6:0] ev_fire;
   logic [6:0] ev_level_q;
   ep_ctrl_s [6:0] ctrl_q;

   // one slice per endpoint; the configured kind picks the writable bits
   genvar e;
   generate
      for (e = 0; e < `EPC_NUM_EP; e++)
      begin : g_ep
         logic is_iso;
         logic [31:0] wmask;
         logic [31:0] set_bits;
         logic [31:0] clr_bits;
         logic [31:0] src;
         logic [31:0] busy_src;
         logic fired;
         logic hit;

         // layout chosen by the configured kind
         assign is_iso = ep_kind_i[e] == KIND_ISO;
         assign wmask = is_iso ? `EPC_MASK_ISO : `EPC_MASK_STD;
         assign hit = wr_fire && wr_ep == 3'(e);
         assign set_bits = (hit && wr_is_set) ? (wr_bits & wmask)
            : 32'h00000000;
         assign clr_bits = (hit && wr_is_clr) ? (wr_bits & wmask)
            : 32'h00000000;
         // every written one lands together; zeros keep the state
         assign state_d[e] = (state_q[e] | set_bits) & ~clr_bits;

         // busy bank source depends on direction
         assign busy_src = 32'(ep_dir_in_i[e] ? all_banks_free_i[e]
            : all_banks_busy_i[e]) << `EPC_B_BUSY;
         assign src = (ep_irq_src_i[e] & ~(32'h1 << `EPC_B_BUSY))
            | busy_src;
         // enables at 8..14, 18, 31, standard 15 and iso 6, 7 gate the sources
         assign fired = |(src & state_q[e] & wmask
            & `EPC_MASK_IRQ_EN);
         // a held source raises the status bit once, on its rising edge
         assign ev_fire[e] = fired && !ev_level_q[e];

         always_ff @(posedge core_clk_i)
         begin
            if (reset_i)
            begin
               state_q[e] <= `EPC_STATE_RST;
               ev_level_q[e] <= 1'b0;
               ctrl_q[e] <= '0;
            end
            else
            begin
               state_q[e] <= state_d[e];
               ev_level_q[e] <= fired;
               ctrl_q[e].on <= state_d[e][`EPC_B_ON];
               ctrl_q[e].auto_commit <= state_d[e][`EPC_B_AUTO];
               ctrl_q[e].force_ack <= !is_iso
                  && state_d[e][`EPC_B_NYET];
               // in side only; a cleared bit means no trailing zlp
               ctrl_q[e].short_guarantee <= ep_dir_in_i[e]
                  && state_d[e][`EPC_B_SHORT]
                  && state_d[e][`EPC_B_AUTO]
                  && end_buf_en_i[e];
               // the raw request is delayed one edge so the gate lines up
               ctrl_q[e].dma_req <= dma_req_i[e]
                  && !(state_q[e][`EPC_B_IRQ_DMA] && fired);
            end
         end
      end
   endgenerate

   // ************************************************************
   // interrupt status and mask
   // ************************************************************
   logic [6:0] irq_status_q;
   logic [6:0] irq_mask_q;
   logic [6:0] status_w1c;
   logic irq_q;
   logic [6:0] ep_irq_q;

   // status bits are write-one-to-clear; the mask is a plain register
   assign status_w1c = (wr_fire && wr_is_status) ? wr_bits[6:0] : 7'h00;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         irq_status_q <= `EPC_IRQ_RST;
         irq_mask_q <= `EPC_IRQ_RST;
         irq_q <= 1'b0;
         ep_irq_q <= 7'h00;
      end
      else
      begin
         // a new event beats a clear in the same cycle
         irq_status_q <= (irq_status_q & ~status_w1c) | ev_fire;
         if (wr_fire && wr_is_mask)
         begin
            irq_mask_q <= wr_bits[6:0];
         end
         // the level looks ahead at this edge's status so it is not late
         irq_q <= |(((irq_status_q & ~status_w1c) | ev_fire)
            & irq_mask_q);
         ep_irq_q <= ev_level_q;
      end
   end

   // ************************************************************
   // read channel
   // ************************************************************
   rd_state_e rd_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic arready_q;
   logic rvalid_q;
   logic ar_take;
   logic rd_in_region;
   logic [2:0] rd_ep;
   logic [4:0] rd_ofs;
   logic rd_ep_ok;
   logic rd_is_state;
   logic rd_is_wo;
   logic [31:0] rd_word;
   logic rd_ok;

   // the answer is decoded from araddr at the edge that takes it
   assign ar_take = s_axi_arvalid_i && arready_q;
   assign rd_in_region = s_axi_araddr_i[31:8] == `EPC_REGION;
   assign rd_ep = s_axi_araddr_i[7:5];
   assign rd_ofs = s_axi_araddr_i[4:0];
   assign rd_ep_ok = rd_in_region && rd_ep != 3'h7;
   assign rd_is_state = rd_ep_ok && rd_ofs == `EPC_OFS_STATE;
   assign rd_is_wo = rd_ep_ok && (rd_ofs == `EPC_OFS_SET
      || rd_ofs == `EPC_OFS_CLR);
   assign rd_ok = rd_is_state || rd_is_wo
      || s_axi_araddr_i == `EPC_IRQ_STATUS
      || s_axi_araddr_i == `EPC_IRQ_MASK;
   // write-only views read as zero
   assign rd_word = rd_is_state ? state_q[rd_ep]
      : (s_axi_araddr_i == `EPC_IRQ_STATUS) ? {25'h0, irq_status_q}
      : (s_axi_araddr_i == `EPC_IRQ_MASK) ? {25'h0, irq_mask_q}
      : 32'h00000000;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         rd_q <= RD_IDLE;
         rdata_q <= 32'h00000000;
         rresp_q <= `EPC_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         case (rd_q)
            RD_IDLE:
            begin
               // refuse another read until rready takes the answer
               arready_q <= !ar_take;
               if (ar_take)
               begin
                  rd_q <= RD_RESP;
                  rvalid_q <= 1'b1;
                  rdata_q <= rd_word;
                  rresp_q <= rd_ok ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
               end
            end
            RD_RESP:
            begin
               if (s_axi_rready_i)
               begin
                  rd_q <= RD_IDLE;
                  arready_q <= 1'b1;
                  rvalid_q <= 1'b0;
               end
            end
            default:
            begin
               rd_q <= RD_IDLE;
               arready_q <= 1'b0;
               rvalid_q <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // every output is a register, so no path runs straight through
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign ep_state_o = state_q;
   assign ep_ctrl_o = ctrl_q;
   assign ep_irq_o = ep_irq_q;
   assign irq_o = irq_q;

endmodule

`default_nettype wire

// [test/ep_ctrl_chk.sv]
/* checker for the endpoint control set/clear block.
   assumes: bound onto ep_ctrl_set_clear; one clock domain. */
`include "ep_ctrl_defs.svh"
`default_nettype none
module ep_ctrl_chk
   import ep_ctrl_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [6:0] dma_req_i,
   input wire logic [6:0][31:0] ep_state_o,
   input wire ep_ctrl_s [6:0] ep_ctrl_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   // ***********************
   // bus and stored state
   // ***********************
   AST_BHOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp lost");
   AST_RHOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata lost");
   AST_KEEP: assert property (!$rose(s_axi_bvalid_o)
      |-> $stable(ep_state_o)) else $error("state moved without write");
   AST_BUSY: assert property ($rose(s_axi_bvalid_o)
      |-> !s_axi_awready_o && !s_axi_wready_o) else $error("ready in resp");
   for (genvar n = 0; n < 7; n++)
   begin : g_ep
      AST_RSV: assert property ((ep_state_o[n] &
         ~(`EPC_MASK_STD | `EPC_MASK_ISO)) == 32'h0) else $error("reserved");
      AST_ON: assert property (ep_ctrl_o[n].on == ep_state_o[n][0])
         else $error("endpoint on mismatch");
      AST_AUTO: assert property (ep_ctrl_o[n].auto_commit
         == ep_state_o[n][1]) else $error("auto commit mismatch");
      AST_ACK: assert property (ep_ctrl_o[n].force_ack
         |-> ep_state_o[n][4]) else $error("force ack without bit");
      AST_SHORT: assert property (ep_ctrl_o[n].short_guarantee
         |-> ep_state_o[n][31] && ep_state_o[n][1]) else $error("short");
      AST_DMA: assert property (ep_ctrl_o[n].dma_req
         |-> $past(dma_req_i[n])) else $error("dma request without raw");
   end
endmodule
bind ep_ctrl_set_clear ep_ctrl_chk i_ep_ctrl_chk (
   .core_clk_i(core_clk_i), .reset_i(reset_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .dma_req_i(dma_req_i), .ep_state_o(ep_state_o), .ep_ctrl_o(ep_ctrl_o)
);
`default_nettype wire

// [test/tb_top.sv]
/* self-checking bench for the endpoint control set/clear block.
   assumes: package, header and block compiled before it. */
`include "ep_ctrl_defs.svh"
`default_nettype none
module tb_top
   import ep_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb;
   logic [6:0][1:0] kind;
   logic [6:0] dir_in, busy, free, ebuf, dreq, ep_irq;
   logic [6:0][31:0] src, state;
   ep_ctrl_s [6:0] ctrl;
   int n_errors = 0, n_compared = 0;
   initial forever #2 clk = ~clk;
   ep_ctrl_set_clear i_ep_ctrl_set_clear (.core_clk_i(clk), .reset_i(rst),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ep_kind_i(kind),
      .ep_dir_in_i(dir_in), .ep_irq_src_i(src), .all_banks_busy_i(busy),
      .all_banks_free_i(free), .end_buf_en_i(ebuf), .dma_req_i(dreq),
      .ep_state_o(state), .ep_ctrl_o(ctrl), .ep_irq_o(ep_irq), .irq_o(irq));
   // ***********************
   // helpers
   // ***********************
   task final_report;
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task stop;
      n_errors++;
      final_report;
   endtask
   function automatic logic [31:0] ad(int n, int o);
      return 32'hF803C100 + 32'(n) * `EPC_EP_STRIDE + 32'(o);
   endfunction
   task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
      int t;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         t++;
      end
      while (bvalid !== 1'b1 && t < 60);
      bready <= 1'b0;
      if (t >= 60) stop;
      chk("bresp", 32'(e), 32'(bresp));
   endtask
   task automatic rd(input logic [31:0] a, d, input logic [1:0] e);
      int t;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         t++;
      end
      while (rvalid !== 1'b1 && t < 60);
      rready <= 1'b0;
      if (t >= 60) stop;
      chk("rdata", d, rdata);
      chk("rresp", 32'(e), 32'(rresp));
   endtask
   // ***********************
   // scenarios
   // ***********************
   task automatic s_views;
      logic [31:0] m;
      for (int n = 0; n < 7; n++)
      begin
         m = (n % 4 == 1) ? `EPC_MASK_ISO : `EPC_MASK_STD;
         rd(ad(n, 12), 32'h0, 2'h0);
         wr(ad(n, 4), 32'hFFFFFFFF, 2'h0);
         chk("state", m, state[n]);
         chk("other", 32'h0, state[(n + 1) % 7]);
         rd(ad(n, 12), m, 2'h0);
         wr(ad(n, 8), 32'h00000011, 2'h0);
         chk("state", m & ~32'h11, state[n]);
         wr(ad(n, 4), 32'h0, 2'h0);
         chk("state", m & ~32'h11, state[n]);
         wr(ad(n, 8), 32'hFFFFFFFF, 2'h0);
         chk("state", 32'h0, state[n]);
      end
   endtask
   task s_ctrl;
      dir_in <= 7'h04;
      ebuf <= 7'h04;
      wr(ad(2, 4), 32'h80000013, 2'h0);
      chk("ctrl", 32'h1E, 32'(ctrl[2]));
      wr(ad(3, 4), 32'h80000013, 2'h0);
      chk("ctrl", 32'h1C, 32'(ctrl[3]));
      wr(ad(2, 8), 32'h80000000, 2'h0);
      chk("ctrl", 32'h1C, 32'(ctrl[2]));
      wr(ad(1, 4), 32'h00000010, 2'h0);
      chk("ctrl", 32'h0, 32'(ctrl[1]));
      wr(ad(2, 8), 32'h00000010, 2'h0);
      chk("ctrl", 32'h18, 32'(ctrl[2]));
      for (int n = 1; n < 4; n++)
         wr(ad(n, 8), 32'hFFFFFFFF, 2'h0);
   endtask
   task s_irq;
      dreq <= 7'h08;
      wr(ad(3, 4), 32'h00000208, 2'h0);
      repeat (2) @(posedge clk);
      chk("dma", 32'h1, 32'(ctrl[3].dma_req));
      src[3] <= 32'h00000200;
      repeat (4) @(posedge clk);
      chk("ep_irq", 32'h08, 32'(ep_irq));
      chk("dma", 32'h0, 32'(ctrl[3].dma_req));
      chk("irq", 32'h0, 32'(irq));
      wr(`EPC_IRQ_MASK, 32'h08, 2'h0);
      repeat (2) @(posedge clk);
      chk("irq", 32'h1, 32'(irq));
      rd(`EPC_IRQ_STATUS, 32'h08, 2'h0);
      src[3] <= 32'h0;
      repeat (4) @(posedge clk);
      wr(`EPC_IRQ_STATUS, 32'h08, 2'h0);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
      chk("dma", 32'h1, 32'(ctrl[3].dma_req));
      wr(ad(3, 4), 32'h00040000, 2'h0);
      busy <= 7'h08;
      repeat (4) @(posedge clk);
      chk("ep_irq", 32'h08, 32'(ep_irq));
      chk("irq", 32'h1, 32'(irq));
      wr(`EPC_IRQ_MASK, 32'h0, 2'h0);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
      wr(ad(3, 8), 32'hFFFFFFFF, 2'h0);
      repeat (4) @(posedge clk);
      chk("ep_irq", 32'h0, 32'(ep_irq));
      busy <= 7'h0;
   endtask
   task s_bad;
      wr(32'hF803C0F0, 32'h1, 2'h2);
      rd(32'hF803C0F0, 32'h0, 2'h2);
      rd(ad(0, 4), 32'h0, 2'h0);
      wr(ad(0, 12), 32'h1, 2'h2);
      chk("state", 32'h0, state[0]);
      wstrb <= 4'h1;
      wr(ad(0, 4), 32'hFFFFFFFF, 2'h0);
      chk("state", 32'h0000001B, state[0]);
      wstrb <= 4'hF;
      wr(ad(0, 8), 32'hFFFFFFFF, 2'h0);
      chk("state", 32'h0, state[0]);
   endtask
   task s_iso;
      wr(ad(1, 4), 32'h000050C0, 2'h0);
      chk("state", 32'h000050C0, state[1]);
      src[1] <= 32'h00000080;
      repeat (4) @(posedge clk);
      chk("ep_irq", 32'h02, 32'(ep_irq));
      src[1] <= 32'h0;
      wr(ad(1, 8), 32'hFFFFFFFF, 2'h0);
      wr(ad(2, 4), 32'h000010C0, 2'h0);
      chk("state", 32'h00001000, state[2]);
      src[2] <= 32'h000000C0;
      repeat (4) @(posedge clk);
      chk("ep_irq", 32'h0, 32'(ep_irq));
      src[2] <= 32'h00001000;
      repeat (4) @(posedge clk);
      chk("ep_irq", 32'h04, 32'(ep_irq));
      src[2] <= 32'h0;
      wr(ad(2, 8), 32'hFFFFFFFF, 2'h0);
   endtask
   task s_reset;
      wr(ad(4, 4), 32'h00000003, 2'h0);
      chk("state", 32'h3, state[4]);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chk("state", 32'h0, state[4]);
      chk("ctrl", 32'h0, 32'(ctrl[4]));
      chk("irq", 32'h0, 32'(irq));
      rd(`EPC_IRQ_STATUS, 32'h0, 2'h0);
      wr(ad(4, 4), 32'h00000001, 2'h0);
      chk("state", 32'h1, state[4]);
   endtask
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
      awaddr <= 32'h0;
      wdata <= 32'h0;
      wstrb <= 4'hF;
      araddr <= 32'h0;
      kind <= 14'h24E4;
      {dir_in, busy, free, ebuf, dreq} <= 35'h0;
      src <= '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      s_views;
      s_ctrl;
      s_irq;
      s_iso;
      s_bad;
      s_reset;
      final_report;
   end
endmodule
`default_nettype wire
